// File: verilog/irfp_top.sv
/*
 Infrared frame port: mode switch between plain serial pins and infrared
 pins, frame length registers, DMA byte fetch and serialiser, interrupts.
 Assumes a DMA agent answering fetch requests with a one-cycle valid pulse,
 and a serial core on the same clock.
*/
// Implementation choice: the plain strobed port.
// Notes on behaviour
// R1: Mode bit 1 routes serial data over the infrared pins; code routes only infrared_rx_pin, core_tx does not reach infrared_tx_pin.
// R2: Mode bit 0 uses plain serial pins; other infrared bits do nothing.
// R3: Mode may change at any moment without an idle condition.
// R4: Software must enable the serial port before infrared use.
// R5: Interrupt status bits are undefined while interrupt enable is 0.
// R6: Checksum status register reads all zero after reset.
// R7: Frame length is 12 bits: low byte, high nibble, reserved upper nibble.
// R8: Programmed length sets the number of bytes in a transmitted frame.
// R9: Software programs length excluding opening flags and stop byte.
// R10: Software places the whole frame in the DMA buffer beforehand.
// R11: High length nibble resets to zero; reserved bits undefined.
// R12: Bytes fetched one at a time, ascending, serialised in order.
`default_nettype none
module irfp_top
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic irq,
   input wire logic core_tx,
   output logic core_rx,
   output logic serial_tx_pin,
   input wire logic serial_rx_pin,
   output logic infrared_tx_pin,
   input wire logic infrared_rx_pin,
   output logic dma_req,
   output logic [11:0] dma_addr,
   input wire logic dma_valid,
   input wire logic [7:0] dma_data
);
   import irfp_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      irfp_state_t st;
      logic [7:0] ctrl;
      logic [7:0] csum;
      logic [11:0] len;
      logic [3:0] len_rsvd;
      logic [1:0] int_stat;
      logic [1:0] int_mask;
      logic uart_en;
      logic [11:0] idx;
      logic [11:0] total;
      logic [2:0] bitn;
      logic [7:0] bcnt;
      logic [7:0] rdata;
      logic irq;
      logic ser_tx;
      logic ir_tx;
      logic core_rx;
      logic dma_req;
      logic [1:0] sync_ser;
      logic [1:0] sync_ir;
   } irfp_regs_t;

   irfp_regs_t r, nxt;
   logic [7:0] buf_q;
   logic buf_wr;

   irfp_byte_buf u_buf
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .wr_en(buf_wr),
      .wr_data(dma_data),
      .rd_data(buf_q)
   );

   function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
      is_ofs = (a == o);
   endfunction

   wire mode_ir = r.ctrl[IRFP_CTRL_MODE];

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      nxt = r;
      buf_wr = 1'b0;
      nxt.dma_req = 1'b0;
      nxt.sync_ser = {r.sync_ser[0], serial_rx_pin};
      nxt.sync_ir = {r.sync_ir[0], infrared_rx_pin};
      // Pin steering follows the mode bit each cycle
      if (mode_ir)
      begin
         nxt.core_rx = r.sync_ir[1]; // R1
         nxt.ser_tx = 1'b1;
      end
      else
      begin
         nxt.core_rx = r.sync_ser[1]; // R2
         nxt.ser_tx = core_tx; // R3
      end
      nxt.rdata = 8'h00;
      if (reg_rd)
      begin
         if (is_ofs(reg_addr, IRFP_OFS_CTRL))
         begin
            nxt.rdata = r.ctrl;
         end
         else if (is_ofs(reg_addr, IRFP_OFS_CSUM))
         begin
            nxt.rdata = r.csum; // R6
         end
         else if (is_ofs(reg_addr, IRFP_OFS_LEN_LO))
         begin
            nxt.rdata = r.len[7:0];
         end
         else if (is_ofs(reg_addr, IRFP_OFS_LEN_HI))
         begin
            nxt.rdata = {r.len_rsvd, r.len[11:8]}; // R7
         end
         else if (is_ofs(reg_addr, IRFP_OFS_INT_STAT))
         begin
            nxt.rdata = {6'h00, r.int_stat};
         end
         else if (is_ofs(reg_addr, IRFP_OFS_INT_MASK))
         begin
            nxt.rdata = {6'h00, r.int_mask};
         end
         else if (is_ofs(reg_addr, IRFP_OFS_UART_EN))
         begin
            nxt.rdata = {7'h00, r.uart_en};
         end
      end
      if (reg_wr)
      begin
         if (is_ofs(reg_addr, IRFP_OFS_CTRL))
         begin
            nxt.ctrl = reg_wdata & ~(8'h01 << IRFP_CTRL_START);
         end
         if (is_ofs(reg_addr, IRFP_OFS_LEN_LO))
         begin
            nxt.len[7:0] = reg_wdata; // R7
         end
         if (is_ofs(reg_addr, IRFP_OFS_LEN_HI))
         begin
            nxt.len[11:8] = reg_wdata[3:0]; // R7
            nxt.len_rsvd = reg_wdata[7:4];
         end
         if (is_ofs(reg_addr, IRFP_OFS_INT_STAT))
         begin
            nxt.int_stat = r.int_stat & ~reg_wdata[1:0];
         end
         if (is_ofs(reg_addr, IRFP_OFS_INT_MASK))
         begin
            nxt.int_mask = reg_wdata[1:0];
         end
         if (is_ofs(reg_addr, IRFP_OFS_UART_EN))
         begin
            nxt.uart_en = reg_wdata[0];
         end
      end
      // ****************************************
      // Frame transmitter
      // ****************************************
      unique case (r.st)
         IRFP_IDLE:
         begin
            nxt.ir_tx = 1'b0;
            // Start needs infrared mode and serial port enabled
            if (reg_wr && is_ofs(reg_addr, IRFP_OFS_CTRL) && reg_wdata[IRFP_CTRL_START]
                && reg_wdata[IRFP_CTRL_MODE] && r.uart_en) // R4
            begin
               nxt.total = r.len + IRFP_FRAME_EXTRA; // R8 R9
               nxt.idx = 12'h000;
               nxt.csum = 8'h00;
               nxt.st = IRFP_FETCH;
            end
         end
         IRFP_FETCH:
         begin
            nxt.dma_req = 1'b1; // R12
            nxt.st = IRFP_WAIT;
         end
         IRFP_WAIT:
         begin
            if (dma_valid)
            begin
               buf_wr = 1'b1;
               nxt.csum = r.csum ^ dma_data;
               nxt.bitn = 3'h0;
               nxt.bcnt = 8'h00;
               nxt.st = IRFP_SHIFT;
            end
         end
         IRFP_SHIFT:
         begin
            nxt.ir_tx = buf_q[r.bitn]; // R12
            if (r.bcnt == IRFP_BIT_CYC - 8'h01)
            begin
               nxt.bcnt = 8'h00;
               nxt.bitn = r.bitn + 3'h1;
               if (r.bitn == 3'h7)
               begin
                  nxt.idx = r.idx + 12'h001; // R12
                  if (r.idx + 12'h001 == r.total) // R8
                  begin
                     nxt.st = IRFP_IDLE;
                     nxt.int_stat[IRFP_INT_DONE] = 1'b1;
                  end
                  else
                  begin
                     nxt.st = IRFP_FETCH;
                  end
               end
            end
            else
            begin
               nxt.bcnt = r.bcnt + 8'h01;
            end
         end
         default:
         begin
            nxt.st = IRFP_IDLE;
         end
      endcase
      // Leaving infrared mode aborts a frame at once
      if (!mode_ir)
      begin
         nxt.st = IRFP_IDLE; // R2 R3
         nxt.ir_tx = 1'b0;
      end
      // Interrupt enable bit gates only the irq output; status bits are still set
      nxt.irq = mode_ir && r.ctrl[IRFP_CTRL_IE] && |(r.int_stat & r.int_mask); // R5
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         r <= '{st: IRFP_IDLE, ctrl: IRFP_CTRL_RST, csum: IRFP_CSUM_RST, len: IRFP_LEN_RST,
                len_rsvd: IRFP_LEN_HI_RSVD, ser_tx: 1'b1, default: '0}; // R6 R11
      end
      else
      begin
         r <= nxt;
      end
   end

   assign reg_rdata = r.rdata;
   assign irq = r.irq;
   assign core_rx = r.core_rx;
   assign serial_tx_pin = r.ser_tx;
   assign infrared_tx_pin = r.ir_tx;
   assign dma_req = r.dma_req;
   assign dma_addr = r.idx;

   // ****************************************
   // Checks
   // ****************************************
   property p_mode_ir_rx;
      @(posedge clk_sys) disable iff (!resetn)
      mode_ir && $past(mode_ir) |=> core_rx == $past(r.sync_ir[1]);
   endproperty
   a_mode_ir_rx: assert property (p_mode_ir_rx) else $error("ir rx not routed"); // R1

   property p_uart_tx;
      @(posedge clk_sys) disable iff (!resetn)
      !mode_ir |=> serial_tx_pin == $past(core_tx);
   endproperty
   a_uart_tx: assert property (p_uart_tx) else $error("serial tx not routed"); // R2

   property p_switch_idle;
      @(posedge clk_sys) disable iff (!resetn)
      !mode_ir |=> r.st == IRFP_IDLE && !infrared_tx_pin;
   endproperty
   a_switch_idle: assert property (p_switch_idle) else $error("frame not stopped"); // R3

   property p_no_start;
      @(posedge clk_sys) disable iff (!resetn)
      r.st == IRFP_IDLE && !r.uart_en |=> r.st == IRFP_IDLE;
   endproperty
   a_no_start: assert property (p_no_start) else $error("start without serial"); // R4

   property p_irq_gate;
      @(posedge clk_sys) disable iff (!resetn)
      !r.ctrl[IRFP_CTRL_IE] |=> !irq;
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled"); // R5

   property p_csum_rst;
      @(posedge clk_sys) $rose(resetn) |-> r.csum == 8'h00;
   endproperty
   a_csum_rst: assert property (p_csum_rst) else $error("csum not zero"); // R6

   property p_len_hi;
      @(posedge clk_sys) disable iff (!resetn)
      reg_wr && reg_addr == IRFP_OFS_LEN_HI |=> r.len[11:8] == $past(reg_wdata[3:0]);
   endproperty
   a_len_hi: assert property (p_len_hi) else $error("length high wrong"); // R7

   property p_frame_end;
      @(posedge clk_sys) disable iff (!resetn)
      r.st == IRFP_SHIFT && $past(r.st) == IRFP_SHIFT && r.idx == r.total |-> 1'b0;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("frame overran"); // R8

   property p_fetch_seq;
      @(posedge clk_sys) disable iff (!resetn)
      dma_req |-> (r.st == IRFP_WAIT || r.st == IRFP_IDLE) ##1 !dma_req;
   endproperty
   a_fetch_seq: assert property (p_fetch_seq) else $error("fetch sequence"); // R12

   property p_addr_step;
      @(posedge clk_sys) disable iff (!resetn)
      $changed(r.idx) && r.st != IRFP_IDLE && $past(r.st) != IRFP_IDLE
         |-> r.idx == $past(r.idx) + 12'h001;
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("address not ascending"); // R12

   property p_ir_serial;
      @(posedge clk_sys) disable iff (!resetn)
      r.st == IRFP_SHIFT && mode_ir |=> infrared_tx_pin == $past(buf_q[r.bitn]);
   endproperty
   a_ir_serial: assert property (p_ir_serial) else $error("wrong bit on ir pin"); // R12

   property p_done_set;
      @(posedge clk_sys) disable iff (!resetn)
      r.st == IRFP_SHIFT && mode_ir && r.bitn == 3'h7 && r.bcnt == IRFP_BIT_CYC - 8'h01
         && r.idx + 12'h001 == r.total |=> r.int_stat[IRFP_INT_DONE] && r.st == IRFP_IDLE;
   endproperty
   a_done_set: assert property (p_done_set) else $error("frame end not flagged"); // R8

   property p_len_lo;
      @(posedge clk_sys) disable iff (!resetn)
      reg_wr && reg_addr == IRFP_OFS_LEN_LO |=> r.len[7:0] == $past(reg_wdata);
   endproperty
   a_len_lo: assert property (p_len_lo) else $error("length low wrong"); // R7
endmodule
`default_nettype wire

// File: verilog/irfp_pkg.sv
/*
 Package for the infrared frame port: register offsets, field positions,
 reset values and timing constants.
 Assumes a single 250 MHz system clock domain.
*/
`default_nettype none
package irfp_pkg;
   localparam logic [7:0] IRFP_OFS_CTRL = 8'hea;
   localparam logic [7:0] IRFP_OFS_CSUM = 8'hec;
   localparam logic [7:0] IRFP_OFS_LEN_LO = 8'hee;
   localparam logic [7:0] IRFP_OFS_LEN_HI = 8'hef;
   localparam logic [7:0] IRFP_OFS_INT_STAT = 8'hf0;
   localparam logic [7:0] IRFP_OFS_INT_MASK = 8'hf1;
   localparam logic [7:0] IRFP_OFS_UART_EN = 8'hf2;
   // Control register fields
   localparam int IRFP_CTRL_MODE = 0;
   localparam int IRFP_CTRL_START = 1;
   localparam int IRFP_CTRL_IE = 3;
   localparam logic [7:0] IRFP_CTRL_RST = 8'h00;
   localparam logic [7:0] IRFP_CSUM_RST = 8'h00;
   localparam logic [11:0] IRFP_LEN_RST = 12'h000;
   localparam logic [3:0] IRFP_LEN_HI_RSVD = 4'h0;
   // Extra bytes beyond the programmed count: two opening flags, one stop
   localparam logic [11:0] IRFP_FRAME_EXTRA = 12'h003;
   localparam int IRFP_BIT_NS = 32;
   localparam int IRFP_CLK_NS = 4;
   localparam logic [7:0] IRFP_BIT_CYC = 8'(IRFP_BIT_NS / IRFP_CLK_NS);
   localparam int IRFP_INT_DONE = 0;
   localparam int IRFP_INT_CSUM = 1;
   typedef enum logic [3:0]
   {
      IRFP_IDLE = 4'h1,
      IRFP_FETCH = 4'h2,
      IRFP_WAIT = 4'h4,
      IRFP_SHIFT = 4'h8
   } irfp_state_t;
endpackage
`default_nettype wire

// File: verilog/irfp_byte_buf.sv
/*
 Small byte buffer holding the frame byte being serialised.
 Assumes writes and reads on clk_sys; read data come from a register.
*/
`default_nettype none
module irfp_byte_buf
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data
);
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rd_data <= 8'h00;
      end
      else if (wr_en)
      begin
         rd_data <= wr_data;
      end
   end
endmodule
`default_nettype wire

// File: test/irfp_dma_model.sv
/*
 Far side: DMA frame buffer and infrared bit receiver.
 Assumes one-cycle dma_req pulses and 8-cycle bits, LSB first.
*/
`default_nettype none
module irfp_dma_model
(
   input wire logic clk_sys,
   input wire logic dma_req,
   input wire logic [11:0] dma_addr,
   output logic dma_valid,
   output logic [7:0] dma_data,
   input wire logic infrared_tx_pin,
   output logic rx_stb,
   output logic [7:0] rx_byte
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:15];
   int slow = 0;
   logic [11:0] a;
   initial {dma_valid, rx_stb, rx_byte, dma_data} = '0;
   // ****************
   // Buffer fetch
   // ****************
   always @(posedge clk_sys)
      if (dma_req)
      begin
         a = dma_addr;
         repeat (slow) @(posedge clk_sys);
         dma_valid <= 1'b1;
         dma_data <= mem[a[3:0]];
         @(posedge clk_sys);
         dma_valid <= 1'b0;
         dma_data <= ~mem[a[3:0]];
      end
   // ****************
   // Bit receiver
   // ****************
   always @(posedge clk_sys)
      if (dma_valid)
      begin
         for (int i = 0; i < 8; i++)
         begin
            repeat (i ? 8 : 4) @(posedge clk_sys);
            rx_byte[i] <= infrared_tx_pin;
         end
         rx_stb <= 1'b1;
         @(posedge clk_sys);
         rx_stb <= 1'b0;
      end
endmodule
`default_nettype wire

// File: test/irfp_top_tb_top.sv
/*
 Testbench for the infrared frame port.
 Assumes the far-side model irfp_dma_model.
*/
`default_nettype none
module irfp_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import irfp_pkg::*;
   logic clk_sys = 0, resetn = 0, reg_wr = 0, reg_rd = 0, core_tx = 1;
   logic serial_rx_pin = 1, infrared_rx_pin = 0, irq, core_rx, serial_tx_pin;
   logic infrared_tx_pin, dma_req, dma_valid, rx_stb;
   logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, rx_byte, dma_data;
   logic [11:0] dma_addr;
   logic [7:0] exp_r[$], exp_f[$];
   int failures = 0, checked = 0, req_cnt = 0;
   bit rd_seen = 0, chk_frame = 1;
   irfp_top i_dut (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .irq, .core_tx, .core_rx, .serial_tx_pin, .serial_rx_pin,
      .infrared_tx_pin, .infrared_rx_pin, .dma_req, .dma_addr, .dma_valid, .dma_data);
   irfp_dma_model i_dma (.clk_sys, .dma_req, .dma_addr, .dma_valid, .dma_data,
      .infrared_tx_pin, .rx_stb, .rx_byte);
   initial forever #2 clk_sys = ~clk_sys;
   // ****************
   // Tasks
   // ****************
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_r.push_back(e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask
   task automatic route(input logic m);
      for (int v = 0; v < 2; v++)
      begin
         @(posedge clk_sys);
         core_tx <= v[0];
         serial_rx_pin <= v[0];
         infrared_rx_pin <= ~v[0];
         repeat (6) @(negedge clk_sys);
         chk(serial_tx_pin, m | v[0]);
         chk(core_rx, m ^ v[0]);
         chk(infrared_tx_pin, 1'b0);
      end
   endtask
   task automatic frame(input int slow, input logic [7:0] mask);
      int k;
      logic [11:0] len;
      logic [7:0] x;
      len = 12'(2 + $urandom % 4);
      x = '0;
      req_cnt = 0;
      i_dma.slow = slow;
      for (int i = 0; i < 16; i++)
         i_dma.mem[i] = 8'($urandom);
      for (int i = 0; i < len + 3; i++)
      begin
         exp_f.push_back(i_dma.mem[i]);
         x ^= i_dma.mem[i];
      end
      wr(IRFP_OFS_LEN_LO, len[7:0]);
      wr(IRFP_OFS_LEN_HI, {4'h0, len[11:8]});
      rd(IRFP_OFS_LEN_LO, len[7:0]);
      wr(IRFP_OFS_INT_MASK, mask);
      wr(IRFP_OFS_CTRL, 8'h0b);
      for (k = 0; k < 3000 && exp_f.size() > 0; k++)
         @(posedge clk_sys);
      if (k == 3000)
      begin
         failures++;
         stop_test();
      end
      repeat (100) @(negedge clk_sys);
      chk(12'(req_cnt), len + 12'h003);
      chk(irq, mask[0]);
      rd(IRFP_OFS_CSUM, x);
      wr(IRFP_OFS_INT_STAT, 8'h01);
      repeat (3) @(negedge clk_sys);
      chk(irq, 1'b0);
   endtask
   // ****************
   // Monitor
   // ****************
   always @(negedge clk_sys)
   begin
      if (rd_seen)
         chk(reg_rdata, exp_r.pop_front());
      rd_seen = reg_rd;
      if (dma_req)
      begin
         chk(dma_addr, 12'(req_cnt));
         req_cnt++;
      end
      if (rx_stb && chk_frame)
         chk(rx_byte, exp_f.size() ? exp_f.pop_front() : 12'hfff);
   end
   // ****************
   // Sequence
   // ****************
   initial
   begin
      int n;
      void'($urandom(39));
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(IRFP_OFS_CSUM, 8'h00);
      rd(IRFP_OFS_LEN_HI, 8'h00);
      rd(8'h10, 8'h00);
      wr(IRFP_OFS_LEN_HI, 8'h5c);
      rd(IRFP_OFS_LEN_HI, 8'h5c);
      route(1'b0);
      wr(IRFP_OFS_CTRL, 8'h0a);
      repeat (20) @(negedge clk_sys);
      chk(12'(req_cnt), 12'h000);
      wr(IRFP_OFS_UART_EN, 8'h01);
      wr(IRFP_OFS_CTRL, 8'h09);
      route(1'b1);
      frame(0, 8'h01);
      frame(3, 8'h00);
      chk_frame = 0;
      req_cnt = 0;
      wr(IRFP_OFS_CTRL, 8'h0b);
      repeat (150) @(posedge clk_sys);
      wr(IRFP_OFS_CTRL, 8'h00);
      repeat (20) @(posedge clk_sys);
      n = req_cnt;
      repeat (200) @(negedge clk_sys);
      chk(12'(req_cnt), 12'(n));
      route(1'b0);
      stop_test();
   end
endmodule
`default_nettype wire
